// >>> logic/rev_consts.svh
// offsets, field positions, reset values and vector numbers of the unit
// assumes it is included by its bare name from the logic folder
`ifndef REV_CONSTS_SVH
`define REV_CONSTS_SVH
// register byte offsets
`define REV_CTRL_OFF 8'h00
`define REV_FCTX_OFF 8'h04
`define REV_TCLR_OFF 8'h08
`define REV_TMR_OFF 8'h0c
`define REV_IDLE_OFF 8'h10
`define REV_STAT_OFF 8'h14
`define REV_SSP_OFF 8'h18
`define REV_PC_OFF 8'h1c
`define REV_CCTL_OFF 8'h20
`define REV_VBR_SEL 3'b010
`define REV_SW_SEL 3'b011
// control fields
`define REV_CTRL_MAJOR 0
`define REV_CTRL_STD 1
// reset values
`define REV_SW_RST 16'h2700
`define REV_CCTL_RST 16'h1f02
`define REV_VBR_RST 32'h0000_0000
// vector numbers and reset vector offsets
`define REV_VEC_SSP 32'h0000_0000
`define REV_VEC_PC 32'h0000_0004
`define REV_V_BUS 8'h02
`define REV_V_ADDR 8'h03
`define REV_V_UNINIT 8'h0f
`define REV_V_EXT 8'h18
`define REV_V_OVT 8'h40
`define REV_V_PER 8'h42
`define REV_V_ICF 8'h5f
`define REV_RESP_OK 2'b00
`define REV_RESP_ERR 2'b10
`endif

// >>> logic/rev_pkg.sv
// types shared by the reset and exception vectoring unit
// assumes nothing of its surroundings
package rev_pkg;
    typedef enum logic [2:0] {
        REV_RST,
        REV_LD_SSP,
        REV_LD_PC,
        REV_FETCH,
        REV_RUN,
        REV_HALT
    } rev_state_e;
endpackage

// >>> logic/rev_unit.sv
// reset sequencing, vector fetch and exception vector dispatch
// assumes a same-clock memory port, same-clock exception sources,
// an axi4-lite master and an asynchronous board reset
`include "rev_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module rev_unit
    import rev_pkg::*;
#(
    parameter int NCTX = 5,
    parameter int NEXT = 8,
    parameter int NPER = 15
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // core reset pin
    input wire logic core_reset_n_in,
    // axi4-lite slave
    input wire logic [31:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [31:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // memory read port
    output logic mem_req_out,
    output logic [31:0] mem_addr_out,
    input wire logic mem_ack_in,
    input wire logic [31:0] mem_data_in,
    input wire logic mem_bus_fault_exception_in,
    input wire logic mem_aerr_in,
    // core state
    output logic in_reset_out,
    output logic halted_out,
    output logic running_out,
    output logic decode_start_out,
    output logic [31:0] instr_out,
    output logic [31:0] ssp_out,
    output logic [31:0] pc_out,
    // exception sources
    input wire logic [2:0] cur_ctx_in,
    input wire logic bus_fault_in,
    input wire logic addr_fault_in,
    input wire logic overtime_in,
    input wire logic [NEXT-1:0] ext_irq_in,
    input wire logic [NPER-1:0] per_irq_in,
    input wire logic exc_done_in,
    // dispatch
    output logic vec_valid_out,
    output logic [7:0] vec_num_out,
    output logic [31:0] vec_addr_out,
    output logic to_master_out,
    output logic may_switch_out
);

// ----------------------------------------
// pin synchroniser
// ----------------------------------------
logic s1_r, s2_r, s3_r, rst_q;
always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        s1_r <= 1'b1;
        s2_r <= 1'b1;
        s3_r <= 1'b1;
        rst_q <= 1'b0;
    end else begin
        s1_r <= core_reset_n_in;
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r) begin
            rst_q <= ~s3_r;
        end
    end
end

// ----------------------------------------
// registers
// ----------------------------------------
rev_state_e state_r;
logic [1:0] ctrl_r;
logic [7:0] fctx_r;
logic [31:0] tclr_r, tmr_r, idle_r, ssp_r, pc_r;
logic [15:0] cctl_r;
logic [31:0] vbr_r [NCTX];
logic [15:0] sw_r [NCTX];
logic busy_r, fbusy_r;

wire logic in_rst = (state_r == REV_RST);
wire logic major = ctrl_r[`REV_CTRL_MAJOR];

// ----------------------------------------
// axi4-lite slave
// ----------------------------------------
logic aw_got_r, w_got_r;
logic [31:0] aw_a_r, w_d_r;
logic [3:0] w_s_r;
wire logic aw_hs = s_axi_awvalid_in && s_axi_awready_out;
wire logic w_hs = s_axi_wvalid_in && s_axi_wready_out;
wire logic do_wr = aw_got_r && w_got_r && !s_axi_bvalid_out;
wire logic [7:0] wa = aw_a_r[7:0];
wire logic whi_ok = (aw_a_r[31:8] == 24'h0);
wire logic wv_sel = whi_ok && (wa[7:5] == `REV_VBR_SEL) && (wa[4:2] < NCTX);
wire logic ws_sel = whi_ok && (wa[7:5] == `REV_SW_SEL) && (wa[4:2] < NCTX);
wire logic [2:0] widx = wa[4:2];
wire logic w_ctrl = whi_ok && (wa == `REV_CTRL_OFF);
wire logic w_fctx = whi_ok && (wa == `REV_FCTX_OFF);
wire logic w_tclr = whi_ok && (wa == `REV_TCLR_OFF);
wire logic w_tmr = whi_ok && (wa == `REV_TMR_OFF);
wire logic w_idle = whi_ok && (wa == `REV_IDLE_OFF);
wire logic w_cctl = whi_ok && (wa == `REV_CCTL_OFF);
wire logic w_ro = whi_ok && (wa == `REV_STAT_OFF || wa == `REV_SSP_OFF ||
    wa == `REV_PC_OFF);
wire logic w_map = w_ctrl || w_fctx || w_tclr || w_tmr || w_idle ||
    w_cctl || wv_sel || ws_sel || w_ro;

function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
        if (s[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
        end
    end
    return r;
endfunction

assign s_axi_awready_out = !aw_got_r;
assign s_axi_wready_out = !w_got_r;
assign s_axi_arready_out = !s_axi_rvalid_out;

always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        aw_a_r <= 32'h0;
        w_d_r <= 32'h0;
        w_s_r <= 4'h0;
        s_axi_bvalid_out <= 1'b0;
        s_axi_bresp_out <= `REV_RESP_OK;
    end else begin
        if (aw_hs) begin
            aw_got_r <= 1'b1;
            aw_a_r <= s_axi_awaddr_in;
        end
        if (w_hs) begin
            w_got_r <= 1'b1;
            w_d_r <= s_axi_wdata_in;
            w_s_r <= s_axi_wstrb_in;
        end
        if (do_wr) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= w_map ? `REV_RESP_OK : `REV_RESP_ERR;
        end else if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
        end
    end
end

// read decode
wire logic [7:0] ra = s_axi_araddr_in[7:0];
wire logic rhi_ok = (s_axi_araddr_in[31:8] == 24'h0);
wire logic [2:0] ridx = ra[4:2];
wire logic rv_sel = rhi_ok && (ra[7:5] == `REV_VBR_SEL) && (ridx < NCTX);
wire logic rs_sel = rhi_ok && (ra[7:5] == `REV_SW_SEL) && (ridx < NCTX);
wire logic [31:0] stat_w = {29'h0, running_out, halted_out, in_reset_out};
wire logic r_hit = rv_sel || rs_sel || (rhi_ok && ra <= `REV_CCTL_OFF &&
    ra[1:0] == 2'b00);
wire logic [31:0] r_val =
    rv_sel ? vbr_r[ridx] :
    rs_sel ? {16'h0, sw_r[ridx]} :
    !rhi_ok ? 32'h0 :
    (ra == `REV_CTRL_OFF) ? {30'h0, ctrl_r} :
    (ra == `REV_FCTX_OFF) ? {24'h0, fctx_r} :
    (ra == `REV_TCLR_OFF) ? tclr_r :
    (ra == `REV_TMR_OFF) ? tmr_r :
    (ra == `REV_IDLE_OFF) ? idle_r :
    (ra == `REV_STAT_OFF) ? stat_w :
    (ra == `REV_SSP_OFF) ? ssp_r :
    (ra == `REV_PC_OFF) ? pc_r :
    (ra == `REV_CCTL_OFF) ? {16'h0, cctl_r} : 32'h0;

always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        s_axi_rvalid_out <= 1'b0;
        s_axi_rdata_out <= 32'h0;
        s_axi_rresp_out <= `REV_RESP_OK;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out <= r_val;
        s_axi_rresp_out <= r_hit ? `REV_RESP_OK : `REV_RESP_ERR;
    end else if (s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
    end
end

// ----------------------------------------
// reset and vector fetch sequence
// ----------------------------------------
wire logic mem_done = mem_req_out && (mem_ack_in || mem_bus_fault_exception_in ||
    (state_r == REV_FETCH && mem_aerr_in));
wire logic mem_bad = mem_bus_fault_exception_in || (state_r == REV_FETCH && mem_aerr_in);

assign mem_req_out = (state_r == REV_LD_SSP) || (state_r == REV_LD_PC) ||
    (state_r == REV_FETCH);
assign mem_addr_out = (state_r == REV_LD_SSP) ? vbr_r[0] + `REV_VEC_SSP :
    (state_r == REV_LD_PC) ? vbr_r[0] + `REV_VEC_PC : pc_r;
assign in_reset_out = in_rst;
assign halted_out = (state_r == REV_HALT);
assign running_out = (state_r == REV_RUN);
assign ssp_out = ssp_r;
assign pc_out = pc_r;

// nested fault in the master has nowhere to go
wire logic fault_ev = running_out && !rst_q && (bus_fault_in || addr_fault_in);
wire logic master_dead = fault_ev && fbusy_r && (cur_ctx_in == 3'd0);

always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        state_r <= REV_RST;
        decode_start_out <= 1'b0;
        instr_out <= 32'h0;
    end else begin
        decode_start_out <= 1'b0;
        if (rst_q) begin
            state_r <= REV_RST;
        end else begin
            case (state_r)
                REV_RST: state_r <= REV_LD_SSP;
                REV_LD_SSP: if (mem_done) begin
                    state_r <= mem_bad ? REV_HALT : REV_LD_PC;
                end
                REV_LD_PC: if (mem_done) begin
                    state_r <= mem_bad ? REV_HALT : REV_FETCH;
                end
                REV_FETCH: if (mem_done) begin
                    state_r <= mem_bad ? REV_HALT : REV_RUN;
                    decode_start_out <= !mem_bad;
                    instr_out <= mem_data_in;
                end
                REV_RUN: if (master_dead) begin
                    state_r <= REV_HALT;
                end
                REV_HALT: state_r <= REV_HALT;
                default: state_r <= REV_HALT;
            endcase
        end
    end
end

// ----------------------------------------
// exception dispatch
// ----------------------------------------
function automatic logic [4:0] first_set(input logic [NPER-1:0] v);
    logic [4:0] r;
    r = 5'h0;
    for (int i = NPER - 1; i >= 0; i--) begin
        if (v[i]) begin
            r = {1'b1, 4'(i)};
        end
    end
    return r;
endfunction

wire logic [4:0] ext_f = first_set(NPER'(ext_irq_in));
wire logic [4:0] per_f = first_set(per_irq_in);
wire logic irq_ev = running_out && !rst_q && !busy_r && !fault_ev &&
    (overtime_in || ext_f[4] || per_f[4]);
wire logic nested = fault_ev && fbusy_r && (cur_ctx_in != 3'd0);
wire logic std_mode = ctrl_r[`REV_CTRL_STD];
wire logic [7:0] sel_vec =
    nested ? `REV_V_ICF :
    bus_fault_in ? `REV_V_BUS :
    addr_fault_in ? `REV_V_ADDR :
    overtime_in ? `REV_V_OVT :
    ext_f[4] ? `REV_V_EXT + {4'h0, ext_f[3:0]} :
    `REV_V_PER + {4'h0, per_f[3:0]};
wire logic sel_master = nested || (!fault_ev && overtime_in && std_mode);
wire logic [2:0] base_ctx = (sel_master || cur_ctx_in >= NCTX) ? 3'd0 :
    cur_ctx_in;
// own base, master base when sent to master or context out of range, offset four times number
wire logic [31:0] sel_addr = vbr_r[base_ctx] + {22'h0, sel_vec, 2'b00};
wire logic take = (fault_ev && !master_dead) || irq_ev;

always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        vec_valid_out <= 1'b0;
        vec_num_out <= 8'h0;
        vec_addr_out <= 32'h0;
        to_master_out <= 1'b0;
        may_switch_out <= 1'b0;
    end else begin
        vec_valid_out <= take;
        if (take) begin
            vec_num_out <= sel_vec;
            vec_addr_out <= sel_addr;
            to_master_out <= sel_master;
            may_switch_out <= !fault_ev && !sel_master;
        end
    end
end

// busy flags: a new dispatch, or for fbusy_r a new first fault, beats a done in the same cycle
always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        busy_r <= 1'b0;
        fbusy_r <= 1'b0;
    end else if (in_rst) begin
        busy_r <= 1'b0;
        fbusy_r <= 1'b0;
    end else begin
        busy_r <= take || (busy_r && !exc_done_in);
        fbusy_r <= (fault_ev && !nested) || (fbusy_r && !exc_done_in);
    end
end

// ----------------------------------------
// register writes and reset loads
// ----------------------------------------
always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        ctrl_r <= 2'h0;
        fctx_r <= 8'h0;
        tclr_r <= 32'h0;
        tmr_r <= 32'h0;
        idle_r <= 32'h0;
        cctl_r <= `REV_CCTL_RST;
        ssp_r <= 32'h0;
        pc_r <= 32'h0;
        for (int i = 0; i < NCTX; i++) begin
            vbr_r[i] <= `REV_VBR_RST;
            sw_r[i] <= `REV_SW_RST;
        end
    end else begin
        if (do_wr) begin
            if (w_ctrl) ctrl_r <= 2'(merge({30'h0, ctrl_r}, w_d_r, w_s_r));
            if (w_fctx) fctx_r <= 8'(merge({24'h0, fctx_r}, w_d_r, w_s_r));
            if (w_tclr) tclr_r <= merge(tclr_r, w_d_r, w_s_r);
            if (w_tmr) tmr_r <= merge(tmr_r, w_d_r, w_s_r);
            if (w_idle) idle_r <= merge(idle_r, w_d_r, w_s_r);
            if (w_cctl) cctl_r <= 16'(merge({16'h0, cctl_r}, w_d_r, w_s_r));
            if (wv_sel) vbr_r[widx] <= merge(vbr_r[widx], w_d_r, w_s_r);
            if (ws_sel) sw_r[widx] <= 16'(merge({16'h0, sw_r[widx]}, w_d_r,
                w_s_r));
        end
        if (nested || (fault_ev && overtime_in && std_mode)) begin
            fctx_r <= {5'h0, cur_ctx_in};
        end
        if (state_r == REV_LD_SSP && mem_ack_in && !mem_bus_fault_exception_in) begin
            ssp_r <= mem_data_in;
        end
        if (state_r == REV_LD_PC && mem_ack_in && !mem_bus_fault_exception_in) begin
            pc_r <= mem_data_in;
        end
        if (in_rst) begin
            // master and timer loads on both kinds
            vbr_r[0] <= `REV_VBR_RST;
            sw_r[0] <= `REV_SW_RST;
            cctl_r <= `REV_CCTL_RST;
            fctx_r <= 8'h0;
            tclr_r <= 32'h0;
            tmr_r <= 32'h0;
            idle_r <= 32'h0;
            if (major) begin
                ctrl_r[`REV_CTRL_STD] <= 1'b0;
                ssp_r <= 32'h0;
                pc_r <= 32'h0;
                for (int i = 1; i < NCTX; i++) begin
                    vbr_r[i] <= `REV_VBR_RST;
                    sw_r[i] <= `REV_SW_RST;
                end
            end
        end
    end
end

// ----------------------------------------
// assertions
// ----------------------------------------
default clocking cb @(posedge clk_in); endclocking
default disable iff (!reset_n_in);

sequence s_release;
    in_reset_out && !rst_q;
endsequence
sequence s_nested;
    nested;
endsequence

AST_ABORT: assert property (rst_q |=> in_reset_out && !mem_req_out)
    else $error("reset did not abort");
AST_PRIO: assert property (rst_q |=> !vec_valid_out)
    else $error("vector dispatched during reset");
AST_MINOR: assert property (in_reset_out && !major |=>
    vbr_r[0] == 32'h0 && sw_r[0] == 16'h2700)
    else $error("minor reset master load wrong");
AST_START: assert property (s_release |=> state_r == REV_LD_SSP &&
    mem_addr_out == vbr_r[0])
    else $error("vector fetch not started after release");
AST_DBLF: assert property ((state_r == REV_LD_SSP ||
    state_r == REV_LD_PC) && mem_bus_fault_exception_in && !rst_q |=> halted_out)
    else $error("vector bus fault did not halt");
AST_CCTL: assert property (in_reset_out |=> cctl_r == 16'h1f02)
    else $error("master control not loaded");
AST_FETCH: assert property (state_r == REV_FETCH && !rst_q &&
    (mem_bus_fault_exception_in || mem_aerr_in) |=> halted_out && !decode_start_out)
    else $error("first fetch fault did not halt");
AST_CLR: assert property (in_reset_out |=> fctx_r == 8'h0 &&
    tmr_r == 32'h0 && idle_r == 32'h0 && tclr_r == 32'h0)
    else $error("timer registers not cleared");
AST_MAJOR: assert property (in_reset_out && major |=>
    vbr_r[NCTX-1] == 32'h0 && sw_r[NCTX-1] == 16'h2700)
    else $error("major reset context load wrong");
AST_NEST: assert property (s_nested |=> vec_valid_out &&
    to_master_out && vec_num_out == 8'h5f)
    else $error("nested fault not sent to master");
AST_UNINIT: assert property (vec_valid_out |->
    vec_num_out != 8'h0f && vec_num_out <= 8'h5f)
    else $error("unassigned vector raised");
AST_LOAD: assert property (state_r == REV_LD_PC && mem_ack_in &&
    !mem_bus_fault_exception_in && !rst_q |=> pc_r == $past(mem_data_in) ##1 1'b1)
    else $error("program counter not loaded");

endmodule
`default_nettype wire

// >>> verif/rev_mem_model.sv
// memory model: reset vector pair and first instruction word
// assumes the unit's same-clock request / answer read port
`timescale 1ns/1ns
`default_nettype none
module rev_mem_model #(
    parameter logic [31:0] SSP_V = 32'h0000_2000,
    parameter logic [31:0] PC_V = 32'h0000_0400
) (
    // clock
    input wire logic clk_in,
    // read port
    input wire logic req_in,
    input wire logic [31:0] addr_in,
    output logic ack_out = 1'b0,
    output logic bus_fault_exception_out = 1'b0,
    output logic aerr_out = 1'b0,
    output logic [31:0] data_out = 32'h0,
    // fault injection: 1 ssp, 2 pc, 3 fetch
    input wire logic [1:0] err_sel_in,
    input wire logic err_addr_in
);
    logic [1:0] wait_r = 2'h0;
    wire [1:0] phase = (addr_in == 32'h0) ? 2'h1 :
                       (addr_in == 32'h4) ? 2'h2 : 2'h3;
    wire hit = (phase == err_sel_in);
    always @(posedge clk_in) begin
        // data bus is not held once an answer is over
        if (ack_out || bus_fault_exception_out || aerr_out || !req_in) begin
            {ack_out, bus_fault_exception_out, aerr_out} <= 3'b000;
            data_out <= ~data_out;
        end else if (wait_r != 2'h0) begin
            wait_r <= wait_r - 2'h1;
            data_out <= ~data_out;
        end else begin
            wait_r <= 2'($urandom_range(2));
            ack_out <= !hit;
            bus_fault_exception_out <= hit && !err_addr_in;
            aerr_out <= hit && err_addr_in;
            data_out <= (phase == 2'h1) ? SSP_V : (phase == 2'h2) ? PC_V :
                        addr_in ^ 32'h5a5a_0000;
        end
    end
endmodule
`default_nettype wire

// >>> verif/rev_unit_tb.sv
// self-checking bench for the reset and vectoring unit
// assumes the memory model on the read port, axi4-lite tasks here
`include "rev_consts.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin \
    samples_checked++; \
    if ((got) !== (ex)) begin \
        fail_count++; \
        $display("unexpected %s exp %h got %h", nm, ex, got); \
    end \
end
module rev_unit_tb;
    import rev_pkg::*;
    localparam logic [31:0] SSP_V = 32'h0000_2000;
    localparam logic [31:0] PC_V = 32'h0000_0400;
    logic clk_in = 0, reset_n_in = 0, core_reset_n_in = 1;
    logic [31:0] s_axi_awaddr_in = 0, s_axi_wdata_in = 0, s_axi_araddr_in = 0;
    logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
    logic s_axi_arvalid_in = 0, s_axi_rready_in = 0;
    logic [3:0] s_axi_wstrb_in = 4'hf;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
    logic s_axi_arready_out, s_axi_rvalid_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
    logic [31:0] s_axi_rdata_out, mem_addr_out, mem_data_in;
    logic mem_req_out, mem_ack_in, mem_bus_fault_exception_in, mem_aerr_in;
    logic in_reset_out, halted_out, running_out, decode_start_out;
    logic [31:0] instr_out, ssp_out, pc_out, vec_addr_out;
    logic [2:0] cur_ctx_in = 0;
    logic bus_fault_in = 0, addr_fault_in = 0, overtime_in = 0;
    logic [7:0] ext_irq_in = 0;
    logic [14:0] per_irq_in = 0;
    logic exc_done_in = 0;
    logic vec_valid_out, to_master_out, may_switch_out;
    logic [7:0] vec_num_out;
    logic [1:0] err_sel = 0;
    logic err_a = 0;
    logic [33:0] rq[$], r_ex;
    logic [41:0] vq[$], v_ex, v_got;
    logic [95:0] bq[$], b_ex;
    logic [31:0] vb[5];
    logic [2:0] c;
    int fail_count = 0, samples_checked = 0, cyc = 0;

    rev_unit dut_u (.clk_in, .reset_n_in, .core_reset_n_in,
        .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
        .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
        .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
        .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
        .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
        .s_axi_rready_in, .mem_req_out, .mem_addr_out, .mem_ack_in,
        .mem_data_in, .mem_bus_fault_exception_in, .mem_aerr_in, .in_reset_out, .halted_out,
        .running_out, .decode_start_out, .instr_out, .ssp_out, .pc_out,
        .cur_ctx_in, .bus_fault_in, .addr_fault_in, .overtime_in, .ext_irq_in,
        .per_irq_in, .exc_done_in, .vec_valid_out, .vec_num_out,
        .vec_addr_out, .to_master_out, .may_switch_out);
    rev_mem_model #(.SSP_V(SSP_V), .PC_V(PC_V)) mem_u (.clk_in(clk_in),
        .req_in(mem_req_out), .addr_in(mem_addr_out), .ack_out(mem_ack_in),
        .bus_fault_exception_out(mem_bus_fault_exception_in), .aerr_out(mem_aerr_in),
        .data_out(mem_data_in), .err_sel_in(err_sel), .err_addr_in(err_a));

    always #5 clk_in = ~clk_in;
    // ----------------------------------------------------------------
    // result watchers
    // ----------------------------------------------------------------
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            test_done();
        end
        if (s_axi_rvalid_out && s_axi_rready_in) begin
            r_ex = rq.pop_front();
            `CHK("read", r_ex, {s_axi_rresp_out, s_axi_rdata_out})
        end
        if (vec_valid_out) begin
            v_ex = vq.pop_front();
            v_got = {vec_num_out, vec_addr_out, to_master_out, may_switch_out};
            `CHK("vector", v_ex, v_got)
            `CHK("assigned", 1'b1, vec_num_out != 8'h0f)
        end
        if (decode_start_out) begin
            b_ex = bq.pop_front();
            `CHK("boot", b_ex, {ssp_out, pc_out, instr_out})
        end
    end
    // ----------------------------------------------------------------
    // drivers
    // ----------------------------------------------------------------
    task automatic test_done();
        if (fail_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        logic aw, w;
        aw = 0;
        w = 0;
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk_in);
            if (!aw && s_axi_awready_out === 1'b1) begin
                aw = 1;
                s_axi_awvalid_in <= 1'b0;
            end
            if (!w && s_axi_wready_out === 1'b1) begin
                w = 1;
                s_axi_wvalid_in <= 1'b0;
            end
        end
        s_axi_bready_in <= 1'b1;
        do @(posedge clk_in); while (s_axi_bvalid_out !== 1'b1);
        `CHK("bresp", er, s_axi_bresp_out)
        s_axi_bready_in <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [33:0] ex);
        rq.push_back(ex);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        do @(posedge clk_in); while (s_axi_arready_out !== 1'b1);
        s_axi_arvalid_in <= 1'b0;
        s_axi_rready_in <= 1'b1;
        do @(posedge clk_in); while (s_axi_rvalid_out !== 1'b1);
        s_axi_rready_in <= 1'b0;
    endtask
    // pending interrupt during reset must not be dispatched
    task automatic core_rst(input logic [1:0] es, input logic ea);
        err_sel <= es;
        err_a <= ea;
        core_reset_n_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        `CHK("in_reset", 1'b1, in_reset_out)
        `CHK("no fetch", 1'b0, mem_req_out)
        ext_irq_in <= 8'h01;
        repeat (2) @(posedge clk_in);
        ext_irq_in <= 8'h00;
        if (es == 2'h0)
            bq.push_back({SSP_V, PC_V, PC_V ^ 32'h5a5a_0000});
        core_reset_n_in <= 1'b1;
        do @(posedge clk_in); while (!running_out && !halted_out);
        @(posedge clk_in);
        `CHK("halt", es != 2'h0, halted_out)
    endtask
    task automatic exc(input logic [25:0] s, input logic [2:0] cx,
                       input logic [41:0] ex, input logic dn);
        vq.push_back(ex);
        {overtime_in, addr_fault_in, bus_fault_in, per_irq_in, ext_irq_in} <= s;
        cur_ctx_in <= cx;
        @(posedge clk_in);
        {overtime_in, addr_fault_in, bus_fault_in, per_irq_in, ext_irq_in} <= 0;
        @(posedge clk_in);
        exc_done_in <= dn;
        @(posedge clk_in);
        exc_done_in <= 1'b0;
    endtask
    // first faults stay local, interrupts not sent to master may switch
    function automatic logic [41:0] ve(logic [7:0] n, logic [2:0] cx,
                                       logic m);
        return {n, vb[m ? 3'h0 : cx] + {22'h0, n, 2'h0}, m,
                !m && n != 8'd2 && n != 8'd3};
    endfunction

    initial begin
        void'($urandom(66976));
        bq.push_back({SSP_V, PC_V, PC_V ^ 32'h5a5a_0000});
        repeat (12) @(posedge clk_in);
        reset_n_in <= 1'b1;
        do @(posedge clk_in); while (running_out !== 1'b1);
        rd(`REV_CCTL_OFF, {2'b00, 32'h1f02});
        rd(`REV_STAT_OFF, {2'b00, 32'h4});
        rd(32'h3c, {2'b10, 32'h0});
        wr(32'h3c, 32'h1, 2'b10);
        for (int i = 0; i < 5; i++) begin
            vb[i] = $urandom;
            wr(32'h40 + 32'(4 * i), vb[i], 2'b00);
            wr(32'h60 + 32'(4 * i), 32'h1234 + 32'(i), 2'b00);
        end
        wr(`REV_TMR_OFF, 32'h5, 2'b00);
        wr(`REV_FCTX_OFF, 32'h3, 2'b00);
        wr(`REV_CTRL_OFF, 32'h0, 2'b00);
        core_rst(2'h0, 1'b0);
        rd(32'h40, {2'b00, 32'h0});
        rd(32'h60, {2'b00, 32'h2700});
        rd(32'h44, {2'b00, vb[1]});
        rd(32'h64, {2'b00, 32'h1235});
        rd(`REV_TMR_OFF, {2'b00, 32'h0});
        rd(`REV_FCTX_OFF, {2'b00, 32'h0});
        wr(`REV_CTRL_OFF, 32'h3, 2'b00);
        core_rst(2'h0, 1'b0);
        rd(32'h44, {2'b00, 32'h0});
        rd(32'h64, {2'b00, 32'h2700});
        rd(`REV_CTRL_OFF, {2'b00, 32'h1});
        for (int k = 0; k < 4; k++) begin
            core_rst(k == 3 ? 2'h3 : 2'(k + 1), k == 3);
            rd(`REV_STAT_OFF, {2'b00, 32'h2});
        end
        core_rst(2'h0, 1'b0);
        for (int i = 0; i < 5; i++) begin
            vb[i] = $urandom;
            wr(32'h40 + 32'(4 * i), vb[i], 2'b00);
        end
        for (int i = 0; i < 8; i++) begin
            c = 3'($urandom_range(4));
            exc({18'h0, 8'(1 << i)}, c, ve(8'(24 + i), c, 0), 1);
        end
        for (int i = 0; i < 15; i++) begin
            c = 3'($urandom_range(4));
            exc({3'h0, 15'(1 << i), 8'h0}, c, ve(8'(66 + i), c, 0), 1);
        end
        exc({3'h0, 15'h1, 8'h08}, 3'h1, ve(8'd27, 3'h1, 0), 1);
        exc({3'h1, 15'h1, 8'h08}, 3'h2, ve(8'd2, 3'h2, 0), 1);
        exc(26'h080_0000, 3'h3, ve(8'd2, 3'h3, 0), 0);
        exc(26'h100_0000, 3'h3, ve(8'd95, 3'h3, 1), 1);
        rd(`REV_FCTX_OFF, {2'b00, 32'h3});
        wr(`REV_CTRL_OFF, 32'h2, 2'b00);
        exc(26'h200_0000, 3'h4, ve(8'd64, 3'h4, 1), 1);
        wr(`REV_CTRL_OFF, 32'h0, 2'b00);
        exc(26'h200_0000, 3'h4, ve(8'd64, 3'h4, 0), 1);
        repeat (3) @(posedge clk_in);
        `CHK("left", 0, vq.size() + rq.size() + bq.size())
        test_done();
    end
endmodule
`default_nettype wire
